/* File: include/qpsi_pkg.sv */
// package: constants and state codes for the quad pot serial interface
`default_nettype none
package qpsi_pkg;
    localparam int          CHAN_N     = 4;       // wiper channels
    localparam int          SPI_W      = 10;      // shift word length
    localparam logic [7:0]  MID_CODE   = 8'h80;   // midscale tap, code 128
    localparam logic [4:0]  ADDR_FIXED = 5'h0b;   // upper slave address bits 01011
    localparam int          INS_CH_HI  = 6;       // instruction channel select, high bit
    localparam int          INS_CH_LO  = 5;       // instruction channel select, low bit
    localparam int          INS_RS     = 4;       // center_wiper_bit
    localparam int          INS_SD     = 3;       // channel_off_bit
    localparam int          INS_O2     = 2;       // aux_output_two
    localparam int          INS_O1     = 1;       // aux_output_one
    localparam logic [2:0]  BIT_FIRST  = 3'h1;    // bit count after the first bit of a frame
    localparam logic [2:0]  BIT_LAST   = 3'h7;    // bit count when the eighth bit arrives
    localparam logic [5:0]  MSYNC_INIT = 6'h2c;   // main synchroniser: select high, pins idle
    localparam logic [2:0]  LSYNC_INIT = 3'h0;    // link synchroniser reset value
    localparam logic        AUX_RST    = 1'b0;    // aux outputs after reset

    // two-wire slave states
    typedef enum logic [3:0] {
        BUS_IDLE  = 4'h0,
        BUS_ADDR  = 4'h1,
        BUS_ACK_A = 4'h2,
        BUS_INSTR = 4'h3,
        BUS_ACK_I = 4'h4,
        BUS_WDATA = 4'h5,
        BUS_ACK_W = 4'h6,
        BUS_READ  = 4'h7,
        BUS_RACK  = 4'h8
    } qpsi_bus_e;
endpackage : qpsi_pkg
`default_nettype wire

/* File: include/qpsi_sync_if.sv */
// interface: a bundle of levels and their synchronised copies
`timescale 1ns/1ps
`default_nettype none
interface qpsi_sync_if #(parameter int W = 1);
    logic [W-1:0] d;   // raw levels
    logic [W-1:0] q;   // synchronised levels
    modport src (output d, input q);
    modport syn (input d, output q);
endinterface : qpsi_sync_if
`default_nettype wire

/* File: rtl/qpsi_sync2.sv */
// two-flop level synchroniser working on a bundle interface
`timescale 1ns/1ps
`default_nettype none
module qpsi_sync2 #(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    qpsi_sync_if.syn        bus
);
    logic [W-1:0] meta_reg;

    // first stage feeds only the second stage; nothing else looks at it
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_reg <= INIT;
            bus.q    <= INIT;
        end else begin
            meta_reg <= bus.d;
            bus.q    <= meta_reg;
        end
    end
endmodule : qpsi_sync2
`default_nettype wire

/* File: rtl/qpsi_top.sv */
// top: shift and two-wire control interfaces for four 8-bit wiper registers
`timescale 1ns/1ps
`default_nettype none
module qpsi_top (
    input  wire logic        MCLK_IN,
    input  wire logic        RSTN_IN,
    input  wire logic        LINK_CLK_IN,
    input  wire logic        LINK_DATA_IN,
    output logic             LINK_DATA_OUT,
    output logic             LINK_DATA_OE_OUT,
    input  wire logic        CS_N_IN,
    input  wire logic        INTERFACE_SELECT_PIN_IN,
    input  wire logic        SHUTDOWN_PIN_N_IN,
    input  wire logic        WIPER_CLEAR_PIN_N_IN,
    input  wire logic        BUS_ADDR_PIN_LOW_IN,
    input  wire logic        BUS_ADDR_PIN_HIGH_IN,
    output logic             CHAIN_OUT_PIN_OUT,
    output logic             CHAIN_OUT_PIN_OE_OUT,
    output logic [31:0]      WIPER_CODE_OUT,
    output logic [3:0]       CHANNEL_ACTIVE_OUT,
    output logic             AUX_OUTPUT_ONE_OUT,
    output logic             AUX_OUTPUT_TWO_OUT
);
    // ****************************************************************
    // declarations
    // ****************************************************************
    logic                    rst_lk_n_reg;   // link-side reset, follows RSTN_IN
    logic                    chain_en_reg;   // low clears the chain driver at once
    logic                    low_reg;
    logic [7:0]              wiper_reg [qpsi_pkg::CHAN_N];
    logic [3:0]              off_reg;
    logic [3:0]              active_reg;
    logic                    aux1_reg;
    logic                    aux2_reg;
    logic                    cs_prev_reg;
    logic                    inst_prev_reg;
    logic                    dat_prev_reg;
    logic [qpsi_pkg::SPI_W-1:0] spi_sh_reg;
    logic                    chain_oe_reg;
    logic                    sda_oe_reg;
    logic                    start_tog_reg;
    logic                    start_seen_reg;
    qpsi_pkg::qpsi_bus_e     st_reg;
    qpsi_pkg::qpsi_bus_e     st_next;
    logic [2:0]              cnt_reg;
    logic [7:0]              sh_reg;
    logic [7:0]              tx_reg;
    logic                    rw_reg;
    logic [1:0]              sel_reg;
    logic [7:0]              ins_reg;
    logic [7:0]              dat_reg;
    logic                    inst_tog_reg;
    logic                    dat_tog_reg;

    qpsi_sync_if #(.W(6))    m_sync ();
    qpsi_sync_if #(.W(3))    l_sync ();

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    assign m_sync.d = {CS_N_IN, INTERFACE_SELECT_PIN_IN, SHUTDOWN_PIN_N_IN,
                       WIPER_CLEAR_PIN_N_IN, inst_tog_reg, dat_tog_reg};
    assign l_sync.d = {INTERFACE_SELECT_PIN_IN, BUS_ADDR_PIN_HIGH_IN, BUS_ADDR_PIN_LOW_IN};

    qpsi_sync2 #(.W(6), .INIT(qpsi_pkg::MSYNC_INIT)) u_msync (
        .clk_in   (MCLK_IN),
        .rst_n_in (rst_lk_n_reg),
        .bus      (m_sync.syn)
    );

    // straps seen by the link logic; the host runs a few clocks before a frame
    qpsi_sync2 #(.W(3), .INIT(qpsi_pkg::LSYNC_INIT)) u_lsync (
        .clk_in   (LINK_CLK_IN),
        .rst_n_in (rst_lk_n_reg),
        .bus      (l_sync.syn)
    );

    wire cs_q   = m_sync.q[5];
    wire mode_q = m_sync.q[4];      // high selects the two-wire slave
    wire shutdown_pin_n_q = m_sync.q[3];
    wire clr_q  = m_sync.q[2];
    wire inst_q = m_sync.q[1];
    wire dat_q  = m_sync.q[0];
    wire mode_lk    = l_sync.q[2];
    wire addr_hi_lk = l_sync.q[1];
    wire addr_lo_lk = l_sync.q[0];

    // ****************************************************************
    // main-domain event decode
    // ****************************************************************
    // chip select is only looked at when the shift interface is chosen
    wire       spi_load = !mode_q && cs_q && !cs_prev_reg;
    wire [1:0] spi_ch   = spi_sh_reg[9:8];
    wire [7:0] spi_dat  = spi_sh_reg[7:0];
    wire       inst_evt = mode_q && (inst_q != inst_prev_reg);
    wire       dat_evt  = mode_q && (dat_q != dat_prev_reg);
    wire [1:0] ins_ch   = {ins_reg[qpsi_pkg::INS_CH_HI], ins_reg[qpsi_pkg::INS_CH_LO]};
    wire       ins_rs   = ins_reg[qpsi_pkg::INS_RS];
    wire       ins_sd   = ins_reg[qpsi_pkg::INS_SD];
    wire       ins_o2   = ins_reg[qpsi_pkg::INS_O2];
    wire       ins_o1   = ins_reg[qpsi_pkg::INS_O1];

    // reset plumbing and edge history; link resets assert one MCLK_IN clock after RSTN_IN
    always_ff @(posedge MCLK_IN) begin
        rst_lk_n_reg  <= RSTN_IN;
        chain_en_reg  <= RSTN_IN && shutdown_pin_n_q;
        low_reg       <= 1'b0;
        cs_prev_reg   <= RSTN_IN ? cs_q : 1'b1;
        inst_prev_reg <= RSTN_IN ? inst_q : 1'b0;
        dat_prev_reg  <= RSTN_IN ? dat_q : 1'b0;
    end

    // ****************************************************************
    // wiper registers, one set per channel
    // ****************************************************************
    for (genvar c = 0; c < qpsi_pkg::CHAN_N; c++) begin : g_ch
        wire hit_spi = spi_load && (spi_ch == 2'(c));
        wire hit_ins = inst_evt && (ins_ch == 2'(c));
        wire hit_dat = dat_evt && (ins_ch == 2'(c));

        // clear pin wins over any write and leaves the code at midscale
        always_ff @(posedge MCLK_IN) begin
            if (!RSTN_IN || !clr_q) begin
                wiper_reg[c] <= qpsi_pkg::MID_CODE;
            end else if (hit_spi) begin
                wiper_reg[c] <= spi_dat;
            end else if (hit_ins && ins_rs) begin
                wiper_reg[c] <= qpsi_pkg::MID_CODE;
            end else if (hit_dat) begin
                wiper_reg[c] <= dat_reg;
            end
        end

        // off bit only gates the channel; the stored code is untouched
        always_ff @(posedge MCLK_IN) begin
            if (!RSTN_IN) begin
                off_reg[c]    <= 1'b0;
                active_reg[c] <= 1'b0;
            end else begin
                if (hit_ins) begin
                    off_reg[c] <= ins_sd;
                end
                active_reg[c] <= shutdown_pin_n_q && !off_reg[c];
            end
        end
    end

    // aux outputs only move on a two-wire instruction
    always_ff @(posedge MCLK_IN) begin
        if (!RSTN_IN) begin
            aux1_reg <= qpsi_pkg::AUX_RST;
            aux2_reg <= qpsi_pkg::AUX_RST;
        end else if (inst_evt) begin
            aux1_reg <= ins_o1;
            aux2_reg <= ins_o2;
        end
    end

    assign WIPER_CODE_OUT     = {wiper_reg[3], wiper_reg[2], wiper_reg[1], wiper_reg[0]};
    assign CHANNEL_ACTIVE_OUT = active_reg;
    assign AUX_OUTPUT_ONE_OUT = aux1_reg;
    assign AUX_OUTPUT_TWO_OUT = aux2_reg;
    assign LINK_DATA_OUT      = low_reg;       // open drain: only ever pulls low
    assign CHAIN_OUT_PIN_OUT  = low_reg;
    assign LINK_DATA_OE_OUT   = sda_oe_reg;
    assign CHAIN_OUT_PIN_OE_OUT = chain_oe_reg;

    // ****************************************************************
    // shift interface, link clock domain
    // ****************************************************************
    // word is read by the main side only after chip select rises and the clock rests
    always_ff @(posedge LINK_CLK_IN or negedge rst_lk_n_reg) begin
        if (!rst_lk_n_reg) begin
            spi_sh_reg <= '0;
        end else if (!CS_N_IN) begin
            spi_sh_reg <= {spi_sh_reg[8:0], LINK_DATA_IN};
        end
    end

    // chain bit leaves on the falling edge; shutdown forces it released
    always_ff @(negedge LINK_CLK_IN or negedge chain_en_reg) begin
        if (!chain_en_reg) begin
            chain_oe_reg <= 1'b0;
        end else begin
            chain_oe_reg <= !spi_sh_reg[9];
        end
    end

    // ****************************************************************
    // two-wire slave, link clock domain
    // ****************************************************************
    // start: data falls while the clock is high; stops need no action here
    always_ff @(negedge LINK_DATA_IN or negedge rst_lk_n_reg) begin
        if (!rst_lk_n_reg) begin
            start_tog_reg <= 1'b0;
        end else if (LINK_CLK_IN) begin
            start_tog_reg <= !start_tog_reg;
        end
    end

    wire       new_frame = mode_lk && (start_tog_reg != start_seen_reg);
    wire       byte_done = (cnt_reg == qpsi_pkg::BIT_LAST);
    wire [7:0] sh_next   = {sh_reg[6:0], LINK_DATA_IN};
    wire [6:0] my_addr   = {qpsi_pkg::ADDR_FIXED, addr_hi_lk, addr_lo_lk};
    wire       addr_hit  = (sh_next[7:1] == my_addr);
    wire       in_ack    = (st_reg == qpsi_pkg::BUS_ACK_A) || (st_reg == qpsi_pkg::BUS_ACK_I)
                        || (st_reg == qpsi_pkg::BUS_ACK_W) || (st_reg == qpsi_pkg::BUS_RACK);
    wire [2:0] cnt_next  = new_frame ? qpsi_pkg::BIT_FIRST : (in_ack ? 3'h0 : cnt_reg + 3'h1);
    wire       addr_take = !new_frame && (st_reg == qpsi_pkg::BUS_ADDR) && byte_done;
    wire       ins_take  = !new_frame && (st_reg == qpsi_pkg::BUS_INSTR) && byte_done;
    wire       dat_take  = !new_frame && (st_reg == qpsi_pkg::BUS_WDATA) && byte_done;
    // wiper codes are quasi-static here; a write racing a read may be torn
    wire       tx_load   = (st_next == qpsi_pkg::BUS_READ) && (st_reg != qpsi_pkg::BUS_READ);
    wire [7:0] tx_next   = tx_load ? wiper_reg[sel_reg] : {tx_reg[6:0], 1'b0};
    // device pulls data low for its acknowledges and for zero read bits
    wire       sda_drive = mode_lk && (((st_reg == qpsi_pkg::BUS_ACK_A) || (st_reg == qpsi_pkg::BUS_ACK_I)
                        || (st_reg == qpsi_pkg::BUS_ACK_W)) || ((st_reg == qpsi_pkg::BUS_READ) && !tx_reg[7]));

    // frame sequencing; a start anywhere restarts at the address byte
    always_comb begin
        st_next = st_reg;
        if (new_frame) begin
            st_next = qpsi_pkg::BUS_ADDR;
        end else begin
            unique case (st_reg)
                qpsi_pkg::BUS_IDLE:  st_next = qpsi_pkg::BUS_IDLE;
                qpsi_pkg::BUS_ADDR:  if (byte_done) st_next = addr_hit ? qpsi_pkg::BUS_ACK_A
                                                                        : qpsi_pkg::BUS_IDLE;
                qpsi_pkg::BUS_ACK_A: st_next = rw_reg ? qpsi_pkg::BUS_READ : qpsi_pkg::BUS_INSTR;
                qpsi_pkg::BUS_INSTR: if (byte_done) st_next = qpsi_pkg::BUS_ACK_I;
                qpsi_pkg::BUS_ACK_I: st_next = qpsi_pkg::BUS_WDATA;
                qpsi_pkg::BUS_WDATA: if (byte_done) st_next = qpsi_pkg::BUS_ACK_W;
                qpsi_pkg::BUS_ACK_W: st_next = qpsi_pkg::BUS_WDATA;
                qpsi_pkg::BUS_READ:  if (byte_done) st_next = qpsi_pkg::BUS_RACK;
                qpsi_pkg::BUS_RACK:  st_next = LINK_DATA_IN ? qpsi_pkg::BUS_IDLE
                                                            : qpsi_pkg::BUS_READ;
                default:             st_next = qpsi_pkg::BUS_IDLE;
            endcase
        end
    end

    // sampling side: everything is taken on the rising link clock
    always_ff @(posedge LINK_CLK_IN or negedge rst_lk_n_reg) begin
        if (!rst_lk_n_reg) begin
            start_seen_reg <= 1'b0;
            st_reg         <= qpsi_pkg::BUS_IDLE;
            cnt_reg        <= 3'h0;
            sh_reg         <= 8'h00;
            tx_reg         <= 8'h00;
        end else begin
            start_seen_reg <= start_tog_reg;
            st_reg         <= st_next;
            cnt_reg        <= cnt_next;
            sh_reg         <= sh_next;
            tx_reg         <= tx_next;
        end
    end

    // captured fields stay put long after their toggle reaches the main side
    always_ff @(posedge LINK_CLK_IN or negedge rst_lk_n_reg) begin
        if (!rst_lk_n_reg) begin
            rw_reg       <= 1'b0;
            sel_reg      <= 2'h0;
            ins_reg      <= 8'h00;
            dat_reg      <= 8'h00;
            inst_tog_reg <= 1'b0;
            dat_tog_reg  <= 1'b0;
        end else begin
            if (addr_take) begin
                rw_reg <= LINK_DATA_IN;
            end
            if (ins_take) begin
                ins_reg      <= sh_next;
                sel_reg      <= sh_next[qpsi_pkg::INS_CH_HI:qpsi_pkg::INS_CH_LO];
                inst_tog_reg <= !inst_tog_reg;
            end
            if (dat_take) begin
                dat_reg     <= sh_next;
                dat_tog_reg <= !dat_tog_reg;
            end
        end
    end

    // driving side: data line moves only on the falling link clock
    always_ff @(negedge LINK_CLK_IN or negedge rst_lk_n_reg) begin
        if (!rst_lk_n_reg) begin
            sda_oe_reg <= 1'b0;
        end else begin
            sda_oe_reg <= sda_drive;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RSTN_IN);

    sequence shutdown_pin_n_held;
        !shutdown_pin_n_q [*2];
    endsequence

    sequence addr_ok;
        addr_take && addr_hit;
    endsequence

    clear_mid_a: assert property (!clr_q |=> WIPER_CODE_OUT == {4{qpsi_pkg::MID_CODE}})
        else $error("clear pin did not set midscale");
    spi_load_a: assert property (spi_load && clr_q |=> wiper_reg[$past(spi_ch)] == $past(spi_dat))
        else $error("shift word not loaded into its channel");
    aux_keep_a: assert property (spi_load && !inst_evt |=> $stable(aux1_reg) && $stable(aux2_reg))
        else $error("shift load changed aux outputs");
    inst_mid_a: assert property (inst_evt && ins_rs && clr_q && !spi_load
                                 |=> wiper_reg[$past(ins_ch)] == qpsi_pkg::MID_CODE)
        else $error("midscale bit ignored");
    off_code_a: assert property (inst_evt && !ins_rs && !spi_load && clr_q |=> $stable(WIPER_CODE_OUT))
        else $error("instruction altered a stored code");
    pin_off_a: assert property (!shutdown_pin_n_q |=> CHANNEL_ACTIVE_OUT == 4'h0)
        else $error("shutdown pin left a channel active");
    aux_set_a: assert property (inst_evt |=> AUX_OUTPUT_ONE_OUT == $past(ins_o1)
                                && AUX_OUTPUT_TWO_OUT == $past(ins_o2))
        else $error("aux outputs do not follow instruction");
    aux_reset_a: assert property (@(posedge MCLK_IN) disable iff (1'b0)
                                  !RSTN_IN |=> !AUX_OUTPUT_ONE_OUT && !AUX_OUTPUT_TWO_OUT)
        else $error("aux outputs not low after reset");
    chain_rel_a: assert property (shutdown_pin_n_held |=> !CHAIN_OUT_PIN_OE_OUT)
        else $error("chain output driven during shutdown");
    addr_ack_a: assert property (@(posedge LINK_CLK_IN) disable iff (!rst_lk_n_reg)
                                 addr_ok |=> LINK_DATA_OE_OUT)
        else $error("matching address not acknowledged");
    addr_skip_a: assert property (@(posedge LINK_CLK_IN) disable iff (!rst_lk_n_reg)
                                  addr_take && !addr_hit |=> !LINK_DATA_OE_OUT)
        else $error("foreign address acknowledged");
endmodule : qpsi_top
`default_nettype wire

/* File: rtl/qpsi_top_unused_guard.sv */
// no logic: the block is qpsi_top with its two qpsi_sync2 synchronisers

/* File: testbench/qpsi_host.sv */
// host model: shift-word master and two-wire master on the link pins
`timescale 1ns/1ps
`default_nettype none
module qpsi_host (
    input  wire logic wire_in,   // data wire level, pull-up applied
    input  wire logic chain_in,  // chain pin level, pull-up applied
    output logic      clk_out,
    output logic      dat_out,
    output logic      cs_n_out
);
    // ****************************************
    // link master, 48 ns bit period
    // ****************************************
    logic [9:0] seen;  // chain levels at rises 11..20 of a long word
    initial begin
        clk_out  = 1'b0;
        dat_out  = 1'b1;
        cs_n_out = 1'b1;
    end
    // data moves only while the clock is low; sample at the rise
    task automatic bit_io(input logic b, output logic s);
        dat_out = b;
        #12 clk_out = 1'b1;
        s = wire_in;
        #24 clk_out = 1'b0;
        #12;
    endtask : bit_io
    // two pulses with nothing selected so the straps settle
    task automatic idle();
        logic s;
        repeat (2) bit_io(1'b1, s);
    endtask : idle
    // msb first word of n bits; chain pin caught at each of the last ten rises
    task automatic shift(input logic [19:0] w, input int n);
        logic s;
        cs_n_out = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            // chain level that a following part takes at this rise
            if (i < 10)
                seen[i] = chain_in;
            bit_io(w[i], s);
        end
        #12 cs_n_out = 1'b1;
        dat_out = ~dat_out;  // released line must not keep the last bit
    endtask : shift
    task automatic start();
        dat_out = 1'b1;
        #12 clk_out = 1'b1;
        #12 dat_out = 1'b0;
        #12 clk_out = 1'b0;
        #12;
    endtask : start
    // stop leaves the bus idle with clock and data high
    task automatic stop();
        dat_out = 1'b0;
        #12 clk_out = 1'b1;
        #12 dat_out = 1'b1;
        #24;
    endtask : stop
    task automatic put(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], s);
        bit_io(1'b1, ack);  // released so the slave can answer
    endtask : put
    task automatic get(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, b[i]);
        bit_io(last, s);
    endtask : get
endmodule : qpsi_host
`default_nettype wire

/* File: testbench/tb_top.sv */
// testbench: shift and two-wire writes, reads, shutdown and clear
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ****************************************
    // harness
    // ****************************************
    typedef struct packed { logic [9:0] w; logic [31:0] e; } qpsi_row_s;
    logic        mclk = 1'b0;
    logic        rstn = 1'b0;
    logic        sel = 1'b0;
    logic        shutdown_pin_n_n = 1'b1;
    logic        clr_n = 1'b1;
    logic [1:0]  adr = 2'b01;   // address straps, high then low
    logic        a;
    logic [7:0]  b;
    int          fail_count = 0;
    int          check_count = 0;
    int          cyc = 0;
    wire         hclk, hdat, hcs_n, oe, coe, aux1, aux2, ldo, cdo;
    wire [31:0]  wip;
    wire [3:0]   act;
    wire         sda = hdat & ~oe;  // open drain with pull-up
    wire         chain = ~coe;
    qpsi_row_s   rows [5] = '{'{10'h011, 32'h80808011}, '{10'h122, 32'h80802211},
        '{10'h233, 32'h80332211}, '{10'h3ff, 32'hff332211}, '{10'h000, 32'hff332200}};
    always #20 mclk = ~mclk;
    qpsi_host i_qpsi_host (.wire_in(sda), .chain_in(chain), .clk_out(hclk), .dat_out(hdat), .cs_n_out(hcs_n));
    qpsi_top i_qpsi_top (.MCLK_IN(mclk), .RSTN_IN(rstn), .LINK_CLK_IN(hclk), .LINK_DATA_IN(sda),
        .LINK_DATA_OUT(ldo), .LINK_DATA_OE_OUT(oe), .CS_N_IN(hcs_n), .INTERFACE_SELECT_PIN_IN(sel),
        .SHUTDOWN_PIN_N_IN(shutdown_pin_n_n), .WIPER_CLEAR_PIN_N_IN(clr_n), .BUS_ADDR_PIN_LOW_IN(adr[0]),
        .BUS_ADDR_PIN_HIGH_IN(adr[1]), .CHAIN_OUT_PIN_OUT(cdo), .CHAIN_OUT_PIN_OE_OUT(coe),
        .WIPER_CODE_OUT(wip), .CHANNEL_ACTIVE_OUT(act), .AUX_OUTPUT_ONE_OUT(aux1), .AUX_OUTPUT_TWO_OUT(aux2));
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic settle();
        repeat (10) @(negedge mclk);
    endtask : settle
    task automatic give_verdict();
        if (fail_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict
    // a hang well past the expected few hundred cycles ends the run
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 8000) begin
            fail_count++;
            give_verdict();
        end
    end
    // ****************************************
    // sequence
    // ****************************************
    initial begin
        repeat (4) @(posedge mclk);
        @(negedge mclk) rstn = 1'b1;
        settle();
        chk(64'({ldo, cdo, aux2, aux1, act, wip}), 64'({8'h0f, 32'h80808080}));
        i_qpsi_host.idle();
        foreach (rows[k]) begin
            i_qpsi_host.shift({10'h0, rows[k].w}, 10);
            settle();
            chk(64'(wip), 64'(rows[k].e));
        end
        i_qpsi_host.shift({10'h2a5, 10'h1c3}, 20);
        settle();
        chk(64'({i_qpsi_host.seen, wip}), 64'({10'h2a5, 32'hff33c300}));
        // top bit zero, so a chain pin still driven in shutdown would show
        @(negedge mclk) shutdown_pin_n_n = 1'b0;
        i_qpsi_host.shift({10'h0, 10'h0c4}, 10);
        settle();
        chk(64'({coe, act, wip}), 64'({5'h00, 32'hff33c3c4}));
        @(negedge mclk) shutdown_pin_n_n = 1'b1;
        @(negedge mclk) clr_n = 1'b0;
        settle();
        chk(64'({act, wip}), 64'({4'hf, 32'h80808080}));
        @(negedge mclk) clr_n = 1'b1;
        @(negedge mclk) sel = 1'b1;
        settle();
        chk(64'({aux2, aux1, wip}), 64'({2'b00, 32'h80808080}));
        i_qpsi_host.idle();
        i_qpsi_host.start();
        i_qpsi_host.put(8'h5c, a);
        chk(64'(a), 64'(1'b1));
        i_qpsi_host.stop();
        // other strap setting: the same byte now names this part
        @(negedge mclk) adr = 2'b10;
        i_qpsi_host.idle();
        i_qpsi_host.start();
        i_qpsi_host.put(8'h5c, a);
        chk(64'(a), 64'(1'b0));
        i_qpsi_host.stop();
        @(negedge mclk) adr = 2'b01;
        i_qpsi_host.idle();
        i_qpsi_host.start();
        i_qpsi_host.put(8'h5a, a);
        chk(64'(a), 64'(1'b0));
        i_qpsi_host.put(8'h44, a);
        chk(64'(a), 64'(1'b0));
        i_qpsi_host.put(8'h5e, a);
        i_qpsi_host.put(8'h3c, a);
        chk(64'(a), 64'(1'b0));
        i_qpsi_host.stop();
        settle();
        chk(64'({aux2, aux1, wip}), 64'({2'b10, 32'h803c8080}));
        i_qpsi_host.start();
        i_qpsi_host.put(8'h5b, a);
        i_qpsi_host.get(1'b0, b);
        chk(64'({a, b}), 64'(9'h03c));
        i_qpsi_host.get(1'b1, b);
        chk(64'(b), 64'(8'h3c));
        i_qpsi_host.stop();
        // instruction alone: channel zero off, aux one up, codes kept
        i_qpsi_host.start();
        i_qpsi_host.put(8'h5a, a);
        i_qpsi_host.put(8'h0a, a);
        i_qpsi_host.stop();
        settle();
        chk(64'({aux2, aux1, act, wip}), 64'({6'h1e, 32'h803c8080}));
        i_qpsi_host.start();
        i_qpsi_host.put(8'h5b, a);
        i_qpsi_host.get(1'b1, b);
        i_qpsi_host.stop();
        chk(64'(b), 64'(8'h80));
        i_qpsi_host.start();
        i_qpsi_host.put(8'h5a, a);
        i_qpsi_host.put(8'h50, a);
        i_qpsi_host.stop();
        settle();
        chk(64'({act, wip}), 64'({4'he, 32'h80808080}));
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
